// >>> logic/led_pwm_map.svh
/*
 * Holds register addresses, reset values, field slices and link counts
 * of the LED driver configuration and open-detect block.
 * Assumes it is included by bare name after the package.
 */
`ifndef LED_PWM_MAP_SVH
`define LED_PWM_MAP_SVH

// -----------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------
`define ADDR_SCAN_LINE    8'h02
`define ADDR_GROUP_COUNT  8'h03
`define ADDR_ROW_WIDTH    8'h04
`define ADDR_GHOST_TIMING 8'h05
`define ADDR_CLOCK_MULT   8'h06
`define ADDR_GAMMA        8'h07
`define ADDR_GAIN         8'h08
`define ADDR_CURRENT_MODE 8'h09
`define ADDR_COUPLING_ENH 8'h0A
`define ADDR_MODE         8'h0C

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RST_SCAN_LINE    8'h2A
`define RST_GROUP_COUNT  8'h3F
`define RST_ROW_WIDTH    8'h20
`define RST_GHOST_TIMING 8'h34
`define RST_CLOCK_MULT   8'h42
`define RST_GAMMA        8'h00
`define RST_GAIN         8'h7F
`define RST_CURRENT_MODE 8'h60
`define RST_COUPLING_ENH 8'hBE
`define RST_MODE         8'h90

// -----------------------------------------------------------------
// Field slices and bit positions
// -----------------------------------------------------------------
`define F_ARM_HIGH      7
`define F_LINE_SET      5:0
`define F_ARM_LOW       7
`define F_GROUP_SET     6:0
`define F_ROW_WIDTH     6:0
`define F_GHOST_FIRST   7:4
`define F_GHOST_SECOND  3:0
`define F_COUPLING_COEF 7:3
`define F_MULT          1:0
`define F_MULT_DIV      2:0
`define F_GAMMA_C_EN    7
`define F_GAMMA_COARSE  6:4
`define F_GAMMA_F_EN    3
`define F_GAMMA_FINE    2:0
`define F_GAIN_COARSE   7:6
`define F_GAIN_FINE     5:0
`define F_INTERNAL_CUR  7
`define F_COUPLING_ONE  4:0
`define F_COUPLING_BST  7:6
`define F_SYNC_MODE     7:6
`define F_BAD_SPOT      1
`define F_DETECT_EN     0

// -----------------------------------------------------------------
// Link counts (shift clocks while the latch strobe is high)
// -----------------------------------------------------------------
`define WRITE_LE_CLKS   4'h5
`define ARM_LE_CLKS     4'hE
`define LE_CNT_MAX      4'hF

`endif

// >>> logic/led_pwm_pkg.sv
/*
 * Holds the state type of the LED driver configuration block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package led_pwm_pkg;

	// -----------------------------------------------------------------
	// Whole block state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]        shift_clock_p;      // Shift clock sync pipe
		logic [1:0]        sdi_p;       // Serial data sync pipe
		logic [2:0]        le_p;        // Latch strobe sync pipe
		logic [2:0]        row_p;       // Row signal sync pipe
		logic [15:0]       sense_s1;    // Open sense, first stage
		logic [15:0]       sense_s2;    // Open sense, second stage
		logic [15:0]       shift;       // Serial shift register
		logic [3:0]        le_cnt;      // Clocks seen while latch high
		logic              armed;       // Arm command seen last
		logic [7:0]        reg02;       // Scan line config
		logic [7:0]        reg03;       // Group count config
		logic [7:0]        reg04;       // Row width config
		logic [7:0]        reg05;       // Ghost removal timing
		logic [7:0]        reg06;       // Clock multiply config
		logic [7:0]        reg07;       // Gamma adjust
		logic [7:0]        reg08;       // Current gain
		logic [7:0]        reg09;       // Current mode and coupling
		logic [7:0]        reg0a;       // Coupling enhance config
		logic [7:0]        reg0c;       // Mode register
		logic [5:0]        line;        // Current scan line
		logic [6:0]        group;       // Current display group
		logic [63:0][15:0] open_map;    // Open channels per line
		logic [7:0]        group_count; // Groups in use
		logic [6:0]        line_count;  // Lines in use
		logic [2:0]        mult;        // Grayscale clock multiplier
		logic [15:0]       max_gray;    // Highest grayscale count
		logic [10:0]       row_time;    // Row time in shift clocks
		logic [15:0]       blank;       // Channels suppressed
		logic              row_start;   // Row period started
		logic              detect;      // Open detection active
	} state_t;

endpackage
`default_nettype wire

// >>> logic/led_pwm_config_open_detect.sv
/*
 * Holds the configuration registers, derived display figures and the
 * open-circuit detection with bad-spot removal of an LED PWM driver.
 * Assumes the serial pins and open sense lines arrive asynchronously,
 * and that the shift clock runs well below half of CLK_SYS.
 */
`timescale 1ns/100ps
`default_nettype none
`include "led_pwm_map.svh"

// How it works
// R1 - Groups in use equal group field plus one
// R2 - Card programs groups as refresh over frame
// R3 - Any group value accepted in every mode
// R4 - Grayscale multiplier is clock field plus one
// R5 - Max gray is four-width-group product, minus one
// R6 - Row time formula, rounded, plus break time
// R7 - Bad-spot removal follows mode bit one
// R8 - Card starts test after power-on or request
// R9 - Detection needs arm high, arm low, enable
// R10 - Card lowers knee and quarters gain first
// R11 - Card parks line zero for one frame
// R12 - Card sweeps all lines and back quickly
// R13 - Row high detects, results latched on low
// R14 - Card pulses row once per scanned line
// R15 - Card ends detection, then enables removal
// R16 - Card holds latch low, clocks continuously
// R17 - Lines scanned equal line field plus one
// R18 - Coarse and fine gamma, each gated separately
// R19 - Gain register holds coarse and fine fields
// R20 - Bit seven picks internal current setting
// R21 - Two sixteen-level ghost times feed row time
// R22 - Coupling level and boost level provided
// R23 - Arm then five-clock latch writes address, data
// R24 - Sync mode field picks display mode
// R25 - Row rising edge starts row period
module led_pwm_config_open_detect #(
	parameter logic [7:0] BREAK_TIME = 8'h00
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic        CE,
	input  wire logic        SHIFT_CLOCK,
	input  wire logic        SERIAL_DATA,
	input  wire logic        LATCH_STROBE,
	input  wire logic        ROW,
	input  wire logic [15:0] OPEN_SENSE,
	output logic      [7:0]  GROUP_COUNT,
	output logic      [6:0]  LINE_COUNT,
	output logic      [2:0]  GRAY_CLOCK_MULT,
	output logic      [15:0] MAX_GRAY,
	output logic      [10:0] ROW_TIME,
	output logic      [5:0]  CURRENT_LINE,
	output logic      [6:0]  CURRENT_GROUP,
	output logic             ROW_START,
	output logic             OPEN_DETECT_ACTIVE,
	output logic             BAD_SPOT_REMOVAL,
	output logic      [15:0] CHANNEL_BLANK,
	output logic      [1:0]  SYNC_MODE,
	output logic      [2:0]  GAMMA_COARSE_LEVEL,
	output logic      [2:0]  GAMMA_FINE_LEVEL,
	output logic      [1:0]  GAIN_COARSE,
	output logic      [5:0]  GAIN_FINE,
	output logic             INTERNAL_CURRENT_SELECT,
	output logic      [4:0]  COUPLING_COEFFICIENT,
	output logic      [4:0]  COUPLING_LEVEL_ONE,
	output logic      [1:0]  COUPLING_BOOST_LEVEL,
	output logic      [3:0]  GHOST_TIME_FIRST,
	output logic      [3:0]  GHOST_TIME_SECOND
);
	import led_pwm_pkg::*;

	// -----------------------------------------------------------------
	// Decoding helpers
	// -----------------------------------------------------------------
	// Level passes only while its switch is on
	function automatic logic [2:0] gated_level(input logic en, input logic [2:0] lvl);
		gated_level = en ? lvl : 3'h0;
	endfunction

	// -----------------------------------------------------------------
	// State and edge terms
	// -----------------------------------------------------------------
	state_t      q;         // Registered state
	state_t      d;         // Next state
	logic        shift_clock_rise; // Shift clock rising edge
	logic        le_fall;   // Latch strobe falling edge
	logic        row_rise;  // Row rising edge
	logic        row_fall;  // Row falling edge
	logic        det_now;   // Detection conditions all met
	logic [9:0]  row_num;   // Row time numerator
	logic [3:0]  row_div;   // Row time divisor
	logic [7:0]  width_p1;  // Row width plus one
	logic [7:0]  group_p1;  // Group field plus one
	logic [17:0] gray_prod; // Full max gray product

	assign shift_clock_rise = q.shift_clock_p[1] & ~q.shift_clock_p[2];
	assign le_fall   = ~q.le_p[1] & q.le_p[2];
	assign row_rise  = q.row_p[1] & ~q.row_p[2];
	assign row_fall  = ~q.row_p[1] & q.row_p[2];
	assign det_now   = q.reg02[`F_ARM_HIGH] & ~q.reg03[`F_ARM_LOW] // R9
		& q.reg0c[`F_DETECT_EN];

	// -----------------------------------------------------------------
	// Derived display figures
	// -----------------------------------------------------------------
	// Numerator and divisor of the row time, full product of max gray
	always_comb begin
		row_num   = 10'({q.reg05[`F_GHOST_FIRST], 1'b0}) // R6 R21
			+ 10'({q.reg05[`F_GHOST_SECOND], 1'b0})
			+ 10'({q.reg04[`F_ROW_WIDTH], 2'b00}) + 10'h008;
		row_div   = {1'b0, q.reg06[`F_MULT_DIV]} + 4'h1;
		width_p1  = {1'b0, q.reg04[`F_ROW_WIDTH]} + 8'h01;
		group_p1  = {1'b0, q.reg03[`F_GROUP_SET]} + 8'h01;
		gray_prod = 18'({width_p1, 2'b00}) * 18'(group_p1) - 18'h00001; // R5
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		d = q;
		// Two-stage pin synchronisers, third stage for edges
		d.shift_clock_p   = {q.shift_clock_p[1:0], SHIFT_CLOCK};
		d.sdi_p    = {q.sdi_p[0], SERIAL_DATA};
		d.le_p     = {q.le_p[1:0], LATCH_STROBE};
		d.row_p    = {q.row_p[1:0], ROW};
		d.sense_s1 = OPEN_SENSE;
		d.sense_s2 = q.sense_s1;
		d.row_start = 1'b0;

		// Shift data while latch low, count clocks while latch high
		if (shift_clock_rise) begin
			if (q.le_p[1]) begin
				if (q.le_cnt != `LE_CNT_MAX) begin
					d.le_cnt = q.le_cnt + 4'h1;
				end
			end else begin
				d.shift = {q.shift[14:0], q.sdi_p[1]}; // R23
			end
		end

		// Command decode on the latch falling edge
		if (le_fall) begin
			d.le_cnt = 4'h0;
			d.armed  = (q.le_cnt == `ARM_LE_CLKS); // R23
			if (q.armed && q.le_cnt == `WRITE_LE_CLKS) begin // R23
				// Address in the first byte, data in the second
				case (q.shift[15:8])
					`ADDR_SCAN_LINE:    d.reg02 = q.shift[7:0]; // R17
					`ADDR_GROUP_COUNT:  d.reg03 = q.shift[7:0]; // R1 R3
					`ADDR_ROW_WIDTH:    d.reg04 = q.shift[7:0];
					`ADDR_GHOST_TIMING: d.reg05 = q.shift[7:0]; // R21
					`ADDR_CLOCK_MULT:   d.reg06 = q.shift[7:0]; // R4
					`ADDR_GAMMA:        d.reg07 = q.shift[7:0]; // R18
					`ADDR_GAIN:         d.reg08 = q.shift[7:0]; // R19
					`ADDR_CURRENT_MODE: d.reg09 = q.shift[7:0]; // R20
					`ADDR_COUPLING_ENH: d.reg0a = q.shift[7:0]; // R22
					`ADDR_MODE:         d.reg0c = q.shift[7:0]; // R24
					default: begin
						// Unmapped address, write dropped
						d.reg0c = q.reg0c;
					end
				endcase
			end
		end

		// Row period start, line and group stepping
		if (row_rise) begin
			d.row_start = 1'b1; // R25
			if (q.line >= q.reg02[`F_LINE_SET]) begin // R17
				d.line = 6'h00;
				if (q.group >= q.reg03[`F_GROUP_SET]) begin // R1
					d.group = 7'h00;
				end else begin
					d.group = q.group + 7'h01;
				end
			end else begin
				d.line = q.line + 6'h01;
			end
		end

		// Open results latched as the row goes low
		if (row_fall && det_now) begin
			d.open_map[q.line] = q.sense_s2; // R13
		end

		// Registered figures and flags
		d.group_count = group_p1; // R1
		d.line_count  = {1'b0, q.reg02[`F_LINE_SET]} + 7'h01; // R17
		d.mult        = {1'b0, q.reg06[`F_MULT]} + 3'h1; // R4
		d.max_gray    = gray_prod[15:0]; // R5
		d.row_time    = 11'((row_num + 10'(row_div >> 1)) / 10'(row_div)) // R6
			+ 11'(BREAK_TIME);
		d.detect      = det_now; // R9
		d.blank       = q.reg0c[`F_BAD_SPOT] ? q.open_map[q.line] : 16'h0000; // R7
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			q       <= '0;
			q.reg02 <= `RST_SCAN_LINE;
			q.reg03 <= `RST_GROUP_COUNT;
			q.reg04 <= `RST_ROW_WIDTH;
			q.reg05 <= `RST_GHOST_TIMING;
			q.reg06 <= `RST_CLOCK_MULT;
			q.reg07 <= `RST_GAMMA;
			q.reg08 <= `RST_GAIN;
			q.reg09 <= `RST_CURRENT_MODE;
			q.reg0a <= `RST_COUPLING_ENH;
			q.reg0c <= `RST_MODE;
		end else if (CE) begin
			q <= d;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign GROUP_COUNT        = q.group_count;
	assign LINE_COUNT         = q.line_count;
	assign GRAY_CLOCK_MULT    = q.mult;
	assign MAX_GRAY           = q.max_gray;
	assign ROW_TIME           = q.row_time;
	assign CURRENT_LINE       = q.line;
	assign CURRENT_GROUP      = q.group;
	assign ROW_START          = q.row_start;
	assign OPEN_DETECT_ACTIVE = q.detect;
	assign BAD_SPOT_REMOVAL   = q.reg0c[`F_BAD_SPOT]; // R7
	assign CHANNEL_BLANK      = q.blank;
	assign SYNC_MODE          = q.reg0c[`F_SYNC_MODE]; // R24
	// Gamma levels read zero while their switch is off
	assign GAMMA_COARSE_LEVEL = gated_level(q.reg07[`F_GAMMA_C_EN], // R18
		q.reg07[`F_GAMMA_COARSE]);
	assign GAMMA_FINE_LEVEL   = gated_level(q.reg07[`F_GAMMA_F_EN], // R18
		q.reg07[`F_GAMMA_FINE]);
	assign GAIN_COARSE        = q.reg08[`F_GAIN_COARSE]; // R19
	assign GAIN_FINE          = q.reg08[`F_GAIN_FINE]; // R19
	assign INTERNAL_CURRENT_SELECT = q.reg09[`F_INTERNAL_CUR]; // R20
	assign COUPLING_COEFFICIENT = q.reg06[`F_COUPLING_COEF]; // R22
	assign COUPLING_LEVEL_ONE = q.reg09[`F_COUPLING_ONE]; // R22
	assign COUPLING_BOOST_LEVEL = q.reg0a[`F_COUPLING_BST]; // R22
	assign GHOST_TIME_FIRST   = q.reg05[`F_GHOST_FIRST]; // R21
	assign GHOST_TIME_SECOND  = q.reg05[`F_GHOST_SECOND]; // R21

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	// Armed write of the gamma register
	sequence gamma_write_s;
		CE && le_fall && q.armed && q.le_cnt == `WRITE_LE_CLKS
			&& q.shift[15:8] == `ADDR_GAMMA;
	endsequence

	// Row edge seen with detection on
	sequence detect_fall_s;
		CE && row_fall && det_now;
	endsequence

	// Row edge at the last line, counter must wrap
	sequence line_wrap_s;
		CE && row_rise && q.line >= q.reg02[`F_LINE_SET];
	endsequence

	group_count_a: assert property (CE |=> GROUP_COUNT == // R1
		{1'b0, $past(q.reg03[6:0])} + 8'h01) else $error("group count wrong");
	clock_mult_a: assert property (CE |=> GRAY_CLOCK_MULT == // R4
		{1'b0, $past(q.reg06[1:0])} + 3'h1) else $error("multiplier wrong");
	max_gray_a: assert property (CE && q.reg04[6:0] == 7'h7F && q.reg03[6:0] == 7'h7F // R5
		|=> MAX_GRAY == 16'hFFFF) else $error("max gray wrong");
	row_time_a: assert property (CE && q.reg05 == 8'h00 && q.reg04[6:0] == 7'h00 // R6
		&& q.reg06[2:0] == 3'h0 |=> ROW_TIME == 11'h008 + 11'(BREAK_TIME))
		else $error("row time wrong");
	gamma_write_a: assert property (gamma_write_s |=> q.reg07 == $past(q.shift[7:0])) // R23
		else $error("register write lost");
	stray_write_a: assert property (CE && le_fall && !q.armed |=> q.reg07 == $past(q.reg07)) // R23
		else $error("unarmed write taken");
	detect_gate_a: assert property (CE |=> OPEN_DETECT_ACTIVE == ($past(q.reg02[7]) // R9
		&& !$past(q.reg03[7]) && $past(q.reg0c[0]))) else $error("detect gate wrong");
	removal_off_a: assert property (CE && !q.reg0c[1] |=> CHANNEL_BLANK == 16'h0000) // R7
		else $error("blank while removal off");
	open_latch_a: assert property (detect_fall_s |=> // R13
		q.open_map[$past(q.line)] == $past(q.sense_s2)) else $error("open result lost");
	line_wrap_a: assert property (line_wrap_s // R17
		|=> CURRENT_LINE == 6'h00) else $error("line did not wrap");
	row_start_a: assert property (CE && row_rise |=> ROW_START ##1 (!ROW_START || !CE)) // R25
		else $error("row start missing");
	line_step_a: assert property (CE && row_rise && q.line < q.reg02[`F_LINE_SET] // R17
		|=> CURRENT_LINE == $past(q.line) + 6'h01) else $error("line did not step");
	group_wrap_a: assert property (line_wrap_s ##0 q.group >= q.reg03[`F_GROUP_SET] // R1
		|=> CURRENT_GROUP == 7'h00) else $error("group did not wrap");
	removal_on_a: assert property (CE && q.reg0c[`F_BAD_SPOT] // R7
		|=> CHANNEL_BLANK == $past(q.open_map[q.line])) else $error("blank not from map");
	open_hold_a: assert property (CE && row_fall && !det_now // R13
		|=> q.open_map == $past(q.open_map)) else $error("map changed while detect off");
	// Clock enable low freezes every register
	enable_hold_a: assert property (!CE |=> q == $past(q))
		else $error("state moved while disabled");

endmodule
`default_nettype wire

// >>> tb/card_model.sv
/*
 * Display card model that drives the serial link and the row line.
 * Assumes it is stepped on the falling edge of the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
module card_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      sdat,
	output logic      latch,
	output logic      row
);
	localparam int HALF = 4; // Shift clock half period in system cycles

	// Idle levels at time zero
	initial begin
		sclk  = 1'b0;
		sdat  = 1'b0;
		latch = 1'b0;
		row   = 1'b0;
	end

	// Whole shift clocks, data line toggles as filler
	task automatic tick(input int n);
		repeat (n) begin
			repeat (HALF) @(negedge clk);
			sclk <= 1'b1;
			repeat (HALF) @(negedge clk);
			sclk <= 1'b0;
			sdat <= ~sdat;
		end
	endtask

	// Latch high for n shift clocks
	task automatic cmd(input int n);
		latch <= 1'b1;
		tick(n);
		repeat (HALF) @(negedge clk);
		latch <= 1'b0;
		repeat (HALF) @(negedge clk);
	endtask

	// Arm, address then data MSB first, write latch
	task automatic write(input logic [7:0] a, input logic [7:0] d, input bit arm);
		logic [15:0] w;
		w = {a, d};
		if (arm) begin
			cmd(14);
		end
		for (int i = 15; i >= 0; i--) begin
			sdat <= w[i];
			repeat (HALF) @(negedge clk);
			sclk <= 1'b1;
			repeat (HALF) @(negedge clk);
			sclk <= 1'b0;
		end
		cmd(5);
	endtask

	// Row high then low, latch low, clock kept running
	task automatic row_pulse(input int hi, input int lo);
		row <= 1'b1;
		tick(hi);
		row <= 1'b0;
		tick(lo);
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * Self-checking bench of the configuration and open-detect block.
 * Assumes the card model drives the link and a register model predicts.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int BRK = 3; // Break time handed to the design
	logic        clk, rst;
	logic [15:0] sense, mg, blank;
	logic [7:0]  gc;
	logic [6:0]  lc, cg;
	logic [10:0] rt;
	logic [5:0]  cl, gfi;
	logic [4:0]  cc, cl1;
	logic [3:0]  g1, g2;
	logic [2:0]  mult, gcl, gfl;
	logic [1:0]  sm, gco, cb;
	logic        rs, oda, bsr, ics, ce;
	wire         sclk, sdat, latch, row;
	int          fail_count, comparisons, line, grp;
	int          rg[16];
	int          map[64];

	// -----------------------------------------------------------------
	// Clock, card and design
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	card_model card (.clk(clk), .sclk(sclk), .sdat(sdat), .latch(latch), .row(row));
	led_pwm_config_open_detect #(.BREAK_TIME(8'h03)) u_dut (
		.CLK_SYS(clk), .RESET(rst), .CE(ce), .SHIFT_CLOCK(sclk), .SERIAL_DATA(sdat),
		.LATCH_STROBE(latch), .ROW(row), .OPEN_SENSE(sense), .GROUP_COUNT(gc),
		.LINE_COUNT(lc), .GRAY_CLOCK_MULT(mult), .MAX_GRAY(mg), .ROW_TIME(rt),
		.CURRENT_LINE(cl), .CURRENT_GROUP(cg), .ROW_START(rs), .OPEN_DETECT_ACTIVE(oda),
		.BAD_SPOT_REMOVAL(bsr), .CHANNEL_BLANK(blank), .SYNC_MODE(sm),
		.GAMMA_COARSE_LEVEL(gcl), .GAMMA_FINE_LEVEL(gfl), .GAIN_COARSE(gco),
		.GAIN_FINE(gfi), .INTERNAL_CURRENT_SELECT(ics), .COUPLING_COEFFICIENT(cc),
		.COUPLING_LEVEL_ONE(cl1), .COUPLING_BOOST_LEVEL(cb), .GHOST_TIME_FIRST(g1),
		.GHOST_TIME_SECOND(g2));

	// -----------------------------------------------------------------
	// Reference model and checks
	// -----------------------------------------------------------------
	function automatic int det();
		return ((rg[2] >> 7) & ~(rg[3] >> 7) & rg[12]) & 1;
	endfunction

	// Register defaults and cleared counters
	task automatic init_model;
		rg = '{default: 0};
		map = '{default: 0};
		rg[2] = 8'h2A; rg[3] = 8'h3F; rg[4] = 8'h20; rg[5] = 8'h34; rg[6] = 8'h42;
		rg[8] = 8'h7F; rg[9] = 8'h60; rg[10] = 8'hBE; rg[12] = 8'h90;
		line = 0;
		grp = 0;
	endtask

	task automatic chk(input string n, input int e, input logic [15:0] g);
		comparisons++;
		if (g !== e[15:0]) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", n, e[15:0], g);
		end
	endtask

	// Every output except ROW_START against the model
	task automatic check_all;
		int num, dv;
		num = 2 * ((rg[5] >> 4) + 1) + 2 * ((rg[5] & 15) + 1) + 4 * ((rg[4] & 127) + 1);
		dv = (rg[6] & 7) + 1;
		chk("group_count", (rg[3] & 127) + 1, {8'h0, gc});
		chk("line_count", (rg[2] & 63) + 1, {9'h0, lc});
		chk("mult", (rg[6] & 3) + 1, {13'h0, mult});
		chk("max_gray", 4 * ((rg[4] & 127) + 1) * ((rg[3] & 127) + 1) - 1, mg);
		chk("row_time", (num + dv / 2) / dv + BRK, {5'h0, rt});
		chk("line", line, {10'h0, cl});
		chk("group", grp, {9'h0, cg});
		chk("detect", det(), {15'h0, oda});
		chk("removal", (rg[12] >> 1) & 1, {15'h0, bsr});
		chk("blank", ((rg[12] >> 1) & 1) ? map[line] : 0, blank);
		chk("sync", rg[12] >> 6, {14'h0, sm});
		chk("gamma_c", (rg[7] >> 7) ? (rg[7] >> 4) & 7 : 0, {13'h0, gcl});
		chk("gamma_f", ((rg[7] >> 3) & 1) ? rg[7] & 7 : 0, {13'h0, gfl});
		chk("gain", rg[8], {8'h0, gco, gfi});
		chk("current", rg[9] >> 7, {15'h0, ics});
		chk("coef", rg[6] >> 3, {11'h0, cc});
		chk("level_one", rg[9] & 31, {11'h0, cl1});
		chk("boost", rg[10] >> 6, {14'h0, cb});
		chk("ghost", rg[5], {8'h0, g1, g2});
	endtask

	// -----------------------------------------------------------------
	// Stimulus tasks
	// -----------------------------------------------------------------
	task automatic do_reset;
		@(negedge clk);
		rst <= 1'b1;
		repeat (10) @(negedge clk);
		rst <= 1'b0;
		init_model;
		repeat (3) @(negedge clk);
		check_all;
	endtask

	// Register write, model follows only armed mapped writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit arm);
		card.write(a, d, arm);
		if (arm && ((a >= 2 && a <= 10) || a == 12)) begin
			rg[a] = d;
		end
		repeat (12) @(negedge clk);
		check_all;
	endtask

	// One row period with line and group stepping
	task automatic row_cycle(input int hi);
		int n;
		n = 0;
		if (line >= (rg[2] & 63)) begin
			line = 0;
			grp = (grp >= (rg[3] & 127)) ? 0 : grp + 1;
		end else begin
			line++;
		end
		if (det() == 1) begin
			map[line] = sense;
		end
		fork
			card.row_pulse(hi, 128);
			begin
				while (rs !== 1'b1 && n < 40) begin
					@(posedge clk);
					#1;
					n++;
				end
				chk("row_start", 1, {15'h0, rs});
				repeat (2) @(negedge clk);
				check_all;
			end
		join
	endtask

	task automatic close_out;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		sense = 16'h0000;
		init_model;
		void'($urandom(2));
		do_reset;
		// Random writes over mapped and unmapped places
		repeat (14) wr(8'($urandom_range(12, 1)), 8'($urandom_range(255, 0)), 1'b1);
		wr(8'h07, 8'hBB, 1'b1);
		// Armed write with the clock enable low is lost
		ce <= 1'b0;
		card.write(8'h07, 8'h5A, 1'b1);
		ce <= 1'b1;
		repeat (12) @(negedge clk);
		check_all;
		wr(8'h07, 8'hFF, 1'b0);
		for (int m = 3; m >= 0; m--) begin
			wr(8'h0C, 8'(m * 64), 1'b1);
		end
		// Group and row width at 7F for max gray, then row time fields zeroed
		wr(8'h03, 8'h7F, 1'b1);
		wr(8'h04, 8'h7F, 1'b1);
		wr(8'h05, 8'h00, 1'b1);
		wr(8'h04, 8'h00, 1'b1);
		wr(8'h06, 8'h00, 1'b1);
		do_reset;
		wr(8'h08, 8'h1F, 1'b1);
		wr(8'h0B, 8'h00, 1'b1);
		wr(8'h02, 8'h82, 1'b1);
		wr(8'h03, 8'h01, 1'b1);
		repeat (2000) @(negedge clk);
		repeat (3) row_cycle(8);
		wr(8'h0C, 8'h01, 1'b1);
		repeat (3) begin
			sense = 16'($urandom);
			row_cycle(32);
		end
		wr(8'h0C, 8'h02, 1'b1);
		repeat (3) begin
			sense = 16'($urandom);
			row_cycle(32);
		end
		wr(8'h0C, 8'h00, 1'b1);
		close_out;
	end

	// Hang guard well beyond the expected run
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		close_out;
	end
endmodule
`default_nettype wire
